// *** hdl/aacp_pkg.sv ***
/*
  Constants for the record-path adaptive coefficient double buffer:
  page numbers, register offsets, field positions and reset values.
  Assumes an APB register bus with one 32-bit word per register index.
*/
package aacp_pkg;
  // Pages that carry this block's registers
  localparam logic [7:0] PAGE_CTRL = 8'h08;
  localparam logic [7:0] PAGE_A_FIRST = 8'h08;
  localparam logic [7:0] PAGE_B_FIRST = 8'h1A;
  localparam int unsigned PAGES_PER_BUF = 9;
  // Register indices within a page (byte address is four times this)
  localparam logic [6:0] REG_PAGE = 7'h00;
  localparam logic [6:0] REG_CTRL = 7'h01;
  localparam logic [6:0] REG_RSVD_FIRST = 7'h02;
  localparam logic [6:0] REG_RSVD_LAST = 7'h07;
  localparam logic [6:0] REG_COEF_FIRST = 7'h08;
  localparam int unsigned BYTES_PER_PAGE = 120;
  localparam int unsigned COEF_BYTES = 3;
  localparam int unsigned COEF_W = 24;
  // Coefficients sit four byte registers apart, so one page holds thirty
  localparam int unsigned COEF_STRIDE = 4;
  // Control register fields
  localparam int unsigned SWAP_BIT = 0;
  localparam int unsigned FLAG_BIT = 1;
  localparam int unsigned ADAPT_BIT = 2;
  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic ADAPT_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic SWAP_RST = 1'b0;
  // Bus geometry
  localparam int unsigned PADDR_W = 12;
endpackage : aacp_pkg

// *** hdl/aacp_core_if.sv ***
/*
  Carrier between the register front end and its two helpers:
  the coefficient store and the buffer swap control.
  Assumes all three sit on the same clock.
*/
`timescale 1ns/10ps
interface aacp_core_if #(
  parameter int unsigned IDXW = 11
);
  logic host_we;
  logic [IDXW-1:0] host_idx;
  logic [7:0] host_wdata;
  logic [7:0] host_rdata;
  logic adapt_en;
  logic req_set;
  logic frame;
  logic req;
  logic flag;
  modport front (output host_we, host_idx, host_wdata, adapt_en, req_set,
    frame, input host_rdata, req, flag);
  modport store (input host_we, host_idx, host_wdata, flag,
    output host_rdata);
  modport swap (input adapt_en, req_set, frame, output req, flag);
endinterface : aacp_core_if

// *** hdl/aacp_swap_ctrl.sv ***
/*
  Swap request and active-buffer flag for the coefficient double buffer.
  Assumes a one-cycle frame boundary pulse on the same clock.
*/
`timescale 1ns/10ps
module aacp_swap_ctrl (
  input wire logic i_clock,
  input wire logic i_rst,
  aacp_core_if.swap c
);
  logic req_ff;
  logic flag_ff;
  logic swap_now;

  assign swap_now = c.adapt_en && c.frame && req_ff;
  assign c.req = req_ff;
  assign c.flag = flag_ff;

  // Request: a new set beats the self clear in the same cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      req_ff <= aacp_pkg::SWAP_RST;
    end else if (!c.adapt_en) begin
      req_ff <= 1'b0;
    end else if (c.req_set) begin
      req_ff <= 1'b1;
    end else if (swap_now) begin
      req_ff <= 1'b0;
    end
  end

  // Flag follows the filter; outside adaptive mode it reads buffer A
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      flag_ff <= aacp_pkg::FLAG_RST;
    end else if (!c.adapt_en) begin
      flag_ff <= 1'b0;
    end else if (swap_now) begin
      flag_ff <= !flag_ff;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_flag_toggles: assert property (
    swap_now |=> flag_ff != $past(flag_ff))
    else $error("flag did not toggle on swap");
  a_req_self_clear: assert property (
    swap_now && !c.req_set |=> !req_ff)
    else $error("swap request not cleared");
  a_req_set_wins: assert property (
    c.adapt_en && c.req_set |=> req_ff)
    else $error("swap request not set");
  a_flag_holds: assert property (
    c.adapt_en && !swap_now |=> $stable(flag_ff))
    else $error("flag moved without swap");
endmodule : aacp_swap_ctrl

// *** hdl/aacp_coef_store.sv ***
/*
  Flip-flop storage for coefficient buffers A and B, with a host byte port
  and a filter port that returns one 24-bit coefficient of the active buffer.
  Assumes the host index already carries the buffer select.
*/
`timescale 1ns/10ps
module aacp_coef_store #(
  parameter int unsigned BUF_BYTES = 1080,
  parameter int unsigned IDXW = 11,
  parameter int unsigned KW = 9
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [KW-1:0] i_filt_idx,
  output logic [aacp_pkg::COEF_W-1:0] o_filt_coef,
  aacp_core_if.store c
);
  logic [7:0] mem [2*BUF_BYTES];
  logic [aacp_pkg::COEF_W-1:0] coef_ff;
  logic [IDXW-1:0] base;

  // Coefficients have no defined reset value, so storage is not reset
  always_ff @(posedge i_clock) begin
    if (c.host_we) begin
      mem[c.host_idx] <= c.host_wdata;
    end
  end

  assign c.host_rdata = mem[c.host_idx];
  // First three of four bytes, most significant first; fourth is spare
  assign base = IDXW'(c.flag ? BUF_BYTES : 0)
    + IDXW'(i_filt_idx * aacp_pkg::COEF_STRIDE);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      coef_ff <= 24'h000000;
    end else begin
      coef_ff <= {mem[base], mem[base + 1'b1], mem[base + 2'h2]};
    end
  end
  assign o_filt_coef = coef_ff;
endmodule : aacp_coef_store

// *** hdl/aacp_top.sv ***
/*
  Record-path adaptive coefficient double buffer: APB register front end,
  page pointer, adaptive control register and coefficient access lock.
  Assumes i_adc_powered and i_frame_start come from logic on i_clock.
*/
// Our own choice: the APB register port.
// Function
// - Offset 0 of every page is the 8-bit page pointer steering accesses
// - Control bit D2 enables adaptive mode, reset zero
// - Read-only D1 shows which buffer the filter uses
// - Writing one to D0 in adaptive mode swaps buffers at frame boundary
// - The swap request bit clears itself after the swap
// - Adaptive off: coefficient access only with channel powered down
// - Coefficients are 24 bits over consecutive bytes, C0 to C29 first
// - Buffer A bytes sit at offsets 8 to 127, read/write, no reset
// - Offsets 2 to 7 are reserved and read zero
// - Following coefficient pages also carry the page pointer at 0
`timescale 1ns/10ps
module aacp_top #(
  parameter int unsigned PAGES_PER_BUF = aacp_pkg::PAGES_PER_BUF
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [aacp_pkg::PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic i_adc_powered,
  input wire logic i_frame_start,
  input wire logic [8:0] i_filt_idx,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_adapt_en,
  output logic o_active_b,
  output logic [aacp_pkg::COEF_W-1:0] o_filt_coef
);
  localparam int unsigned BUF_BYTES = PAGES_PER_BUF
    * aacp_pkg::BYTES_PER_PAGE;
  localparam int unsigned IDXW = $clog2(2 * BUF_BYTES);
  localparam logic [7:0] PAGE_A_LAST = 8'(aacp_pkg::PAGE_A_FIRST
    + PAGES_PER_BUF - 1);
  localparam logic [7:0] PAGE_B_LAST = 8'(aacp_pkg::PAGE_B_FIRST
    + PAGES_PER_BUF - 1);

  aacp_core_if #(.IDXW(IDXW)) core ();

  logic [7:0] page_ff;
  logic adapt_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic setup;
  logic wr_fire;
  logic [6:0] reg_idx;
  logic bad_addr;
  logic in_a;
  logic in_b;
  logic is_coef;
  logic is_ctrl;
  logic is_rsvd;
  logic locked;
  logic refused;
  logic [7:0] page_rel;
  logic [IDXW-1:0] byte_idx;
  logic [7:0] ctrl_val;
  logic [7:0] rd_val;

  // Bus phases; a write lands only at the edge that completes it
  assign setup = i_psel && !i_penable;
  assign wr_fire = i_psel && i_penable && pready_ff && i_pwrite
    && !pslverr_ff && i_pstrb[0];
  assign reg_idx = i_paddr[8:2];
  // Only word-aligned addresses inside one page are mapped
  assign bad_addr = (i_paddr[11:9] != 3'h0) || (i_paddr[1:0] != 2'h0);

  // Page decode; coefficient pages continue across the block
  assign in_a = (page_ff >= aacp_pkg::PAGE_A_FIRST)
    && (page_ff <= PAGE_A_LAST);
  assign in_b = (page_ff >= aacp_pkg::PAGE_B_FIRST)
    && (page_ff <= PAGE_B_LAST);
  assign is_coef = (in_a || in_b)
    && (reg_idx >= aacp_pkg::REG_COEF_FIRST);
  assign is_ctrl = (page_ff == aacp_pkg::PAGE_CTRL)
    && (reg_idx == aacp_pkg::REG_CTRL);
  assign is_rsvd = (reg_idx >= aacp_pkg::REG_RSVD_FIRST)
    && (reg_idx <= aacp_pkg::REG_RSVD_LAST);
  assign page_rel = in_b ? page_ff - aacp_pkg::PAGE_B_FIRST
    : page_ff - aacp_pkg::PAGE_A_FIRST;

  // Flat byte index: buffer B follows buffer A in the store
  assign byte_idx = IDXW'(in_b ? BUF_BYTES : 0)
    + IDXW'(page_rel * aacp_pkg::BYTES_PER_PAGE)
    + IDXW'(reg_idx - aacp_pkg::REG_COEF_FIRST);

  // Running channel without adaptive mode would see torn coefficients
  assign locked = !adapt_ff && i_adc_powered;
  // In adaptive mode the host may not touch the buffer the filter reads
  assign refused = is_coef && (locked
    || (adapt_ff && (in_b == core.flag)));

  // Control register image; upper bits reserved and zero
  always_comb begin
    ctrl_val = 8'h00;
    ctrl_val[aacp_pkg::ADAPT_BIT] = adapt_ff;
    ctrl_val[aacp_pkg::FLAG_BIT] = core.flag;
    ctrl_val[aacp_pkg::SWAP_BIT] = core.req;
  end

  // Read mux; anything not decoded reads zero
  always_comb begin
    rd_val = 8'h00;
    if (reg_idx == aacp_pkg::REG_PAGE) begin
      rd_val = page_ff;
    end else if (is_ctrl) begin
      rd_val = ctrl_val;
    end else if (is_rsvd) begin
      rd_val = 8'h00;
    end else if (is_coef && !refused) begin
      rd_val = core.host_rdata;
    end
  end

  // APB answer: ready in the first access cycle, zero wait states
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pready_ff <= 1'b1;
      pslverr_ff <= bad_addr || refused;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Read data captured in setup, held through the access cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff <= 32'h00000000;
    end else if (setup) begin
      prdata_ff <= (bad_addr || i_pwrite) ? 32'h00000000
        : {24'h000000, rd_val};
    end
  end

  // Page pointer exists at offset 0 of every page
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      page_ff <= aacp_pkg::PAGE_RST;
    end else if (wr_fire && (reg_idx == aacp_pkg::REG_PAGE)) begin
      page_ff <= i_pwdata[7:0];
    end
  end

  // Adaptive enable; reserved bits of the word are dropped
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      adapt_ff <= aacp_pkg::ADAPT_RST;
    end else if (wr_fire && is_ctrl) begin
      adapt_ff <= i_pwdata[aacp_pkg::ADAPT_BIT];
    end
  end

  // Swap request only counts when the same write keeps adaptive mode on
  assign core.req_set = wr_fire && is_ctrl
    && i_pwdata[aacp_pkg::SWAP_BIT]
    && i_pwdata[aacp_pkg::ADAPT_BIT];
  assign core.adapt_en = adapt_ff;
  assign core.frame = i_frame_start;
  // Reserved offsets ignore writes; refused accesses never reach storage
  // Refusal is looked at again: a swap between setup and access moves it
  assign core.host_we = wr_fire && is_coef && !refused;
  assign core.host_idx = byte_idx;
  assign core.host_wdata = i_pwdata[7:0];

  aacp_swap_ctrl u_swap (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .c(core.swap)
  );

  aacp_coef_store #(
    .BUF_BYTES(BUF_BYTES),
    .IDXW(IDXW),
    .KW(9)
  ) u_store (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_filt_idx(i_filt_idx),
    .o_filt_coef(o_filt_coef),
    .c(core.store)
  );

  // Mirror flag into a top-level flop so the output is registered
  logic active_ff;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      active_ff <= aacp_pkg::FLAG_RST;
    end else begin
      active_ff <= core.flag;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_adapt_en = adapt_ff;
  assign o_active_b = active_ff;

  // All checks are off while reset is held
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Setup cycle of any transfer
  sequence s_setup;
    i_psel && !i_penable;
  endsequence

  // Setup of a read that decodes to a valid word
  sequence s_rd_setup;
    i_psel && !i_penable && !i_pwrite && !bad_addr;
  endsequence

  // Access edge at which a write lands
  sequence s_wr_access;
    i_psel && i_penable && o_pready && i_pwrite && !o_pslverr
      && i_pstrb[0];
  endsequence

  // Frame boundary that finds a pending exchange
  sequence s_swap;
    adapt_ff && i_frame_start && core.req;
  endsequence

  // Register bus checks
  a_ready_after_setup: assert property (s_setup |=> o_pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_page_write: assert property (
    s_wr_access ##0 (reg_idx == aacp_pkg::REG_PAGE)
    |=> page_ff == $past(i_pwdata[7:0]))
    else $error("page pointer not written");
  a_page_stable: assert property (
    !(wr_fire && (reg_idx == aacp_pkg::REG_PAGE)) |=> $stable(page_ff))
    else $error("page pointer moved without write");
  a_page_read: assert property (
    s_rd_setup ##0 (reg_idx == aacp_pkg::REG_PAGE)
    |=> o_prdata[7:0] == $past(page_ff))
    else $error("page pointer read wrong");
  a_adapt_write: assert property (s_wr_access ##0 is_ctrl
    |=> o_adapt_en == $past(i_pwdata[aacp_pkg::ADAPT_BIT]))
    else $error("adaptive enable not written");
  a_adapt_stable: assert property (!(wr_fire && is_ctrl)
    |=> $stable(adapt_ff))
    else $error("adaptive enable moved without write");
  a_rsvd_reads_zero: assert property (s_setup ##0 is_rsvd
    |=> o_prdata == 32'h00000000)
    else $error("reserved offset read non-zero");
  a_write_reads_zero: assert property (s_setup ##0 i_pwrite
    |=> o_prdata == 32'h00000000)
    else $error("write returned read data");
  a_lock_refuses: assert property (
    s_setup ##0 (is_coef && locked)
    |=> o_pslverr && o_prdata == 32'h00000000)
    else $error("locked coefficient access passed");
  a_refused_zero: assert property (s_setup ##0 refused
    |=> o_pslverr && o_prdata == 32'h00000000)
    else $error("filter buffer reachable by host");
  a_lock_no_write: assert property (locked |-> !core.host_we)
    else $error("coefficient written while locked");
  a_err_no_write: assert property (o_pslverr |-> !core.host_we)
    else $error("refused access reached storage");
  a_bad_addr_err: assert property (s_setup ##0 bad_addr
    |=> o_pslverr && o_prdata == 32'h00000000)
    else $error("misaligned access not refused");
  a_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  // Swap and flag checks
  a_swap_flag_path: assert property (s_swap
    |=> core.flag != $past(core.flag) ##1 o_active_b == $past(core.flag))
    else $error("swap did not move flag");
  a_req_set_path: assert property (
    s_wr_access ##0 (is_ctrl && adapt_ff && i_pwdata[aacp_pkg::SWAP_BIT]
    && i_pwdata[aacp_pkg::ADAPT_BIT]) |=> core.req)
    else $error("swap request not taken");
  a_no_early_swap: assert property (adapt_ff && !i_frame_start
    |=> $stable(core.flag))
    else $error("flag moved off a frame boundary");
  a_off_flag_clear: assert property (!adapt_ff |=> !core.flag)
    else $error("flag set outside adaptive mode");
  a_active_mirror: assert property (o_active_b == $past(core.flag))
    else $error("active flag output lags wrongly");
  a_ctrl_readback: assert property (s_rd_setup ##0 is_ctrl
    |=> o_prdata[aacp_pkg::FLAG_BIT] == $past(core.flag))
    else $error("flag readback wrong");
  a_req_readback: assert property (s_rd_setup ##0 is_ctrl
    |=> o_prdata[aacp_pkg::SWAP_BIT] == $past(core.req))
    else $error("request readback wrong");
endmodule : aacp_top

// *** tb/aacp_host_model.sv ***
/*
  Host controller model: an APB master that reaches the codec registers.
  Assumes a slave on the same clock that answers with pready.
*/
`timescale 1ns/10ps
module aacp_host_model (
  input wire logic i_clock,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  // Idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h00000000;
    o_pstrb = 4'h0;
  end

  // One transfer; page moves are plain writes to index 0
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [7:0] d, output logic [7:0] rd, output logic err,
    output bit ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    err = 1'b0;
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= {24'h000000, d}; // Callers send zero to reserved
    o_pstrb <= 4'hF;
    @(posedge i_clock);
    o_penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge i_clock);
      if (i_pready === 1'b1) begin
        ok = 1'b1;
        rd = i_prdata[7:0];
        err = i_pslverr; // Locked access comes back refused
        break;
      end
    end
    // Released bus shows a changed pattern, not the old value
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~{24'h000000, d};
  endtask : xfer
endmodule : aacp_host_model

// *** tb/adc_adaptive_coef_pingpong_tb.sv ***
/*
  Bench for the adaptive coefficient double buffer: register sequences
  through the host model, frame pulses and filter reads.
  Assumes two pages per buffer so page 9 exists.
*/
`timescale 1ns/10ps
module adc_adaptive_coef_pingpong_tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, adapt_en, active_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic adc_powered = 1'b1;
  logic frame_start = 1'b0;
  logic [8:0] filt_idx = 9'h000;
  logic [23:0] filt_coef;
  int bad_count = 0;
  int cmp_count = 0;
  int i;
  logic [7:0] rd_x;
  logic err_x;
  bit ok_x;

  // Free-running 250 MHz clock
  always #2 i_clock = ~i_clock;

  aacp_host_model host (.i_clock(i_clock), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .o_pstrb(pstrb));

  aacp_top #(.PAGES_PER_BUF(2)) uut (.i_clock(i_clock), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .i_adc_powered(adc_powered), .i_frame_start(frame_start),
    .i_filt_idx(filt_idx), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_adapt_en(adapt_en), .o_active_b(active_b),
    .o_filt_coef(filt_coef));

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
    input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
        exp);
    end
  endtask : check

  // Register access on the current page with expected outcome
  task automatic acc(input logic wr, input logic [6:0] idx,
    input logic [7:0] d, input logic xerr, input logic [7:0] exp);
    logic [7:0] rd;
    logic err;
    bit ok;
    host.xfer(wr, {3'b000, idx, 2'b00}, d, rd, err, ok);
    if (!ok) begin
      bad_count++;
      $display("unexpected at %0t: no pready", $time);
      summarize();
    end
    check({23'h0, err}, {23'h0, xerr}, "pslverr");
    if (!wr)
      check({16'h0, rd}, {16'h0, exp}, "read data");
  endtask : acc

  // Move the page pointer and read it back
  task automatic page(input logic [7:0] p);
    acc(1'b1, 7'h00, p, 1'b0, 8'h00);
    acc(1'b0, 7'h00, 8'h00, 1'b0, p);
  endtask : page

  // One-cycle frame boundary pulse, then let the flag settle
  task automatic frame;
    @(posedge i_clock);
    frame_start <= 1'b1;
    @(posedge i_clock);
    frame_start <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask : frame

  task automatic filt(input logic [8:0] k, input logic [23:0] exp);
    @(posedge i_clock);
    filt_idx <= k;
    repeat (2) @(posedge i_clock);
    check(filt_coef, exp, "filter coef");
  endtask : filt

  // Hang guard well above the run length
  initial begin
    #200000;
    bad_count++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end

  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    acc(1'b0, 7'h00, 8'h00, 1'b0, 8'h00);
    check({23'h0, adapt_en}, 24'h0, "adapt reset");
    check({23'h0, active_b}, 24'h0, "flag reset");
    // Misaligned word is refused and reads zero
    host.xfer(1'b0, 12'h005, 8'h00, rd_x, err_x, ok_x);
    check({15'h0, ok_x, rd_x}, 24'h100, "misaligned read");
    check({23'h0, err_x}, 24'h1, "misaligned error");
    page(8'h08);
    acc(1'b0, 7'h01, 8'h00, 1'b0, 8'h00);
    for (i = 2; i <= 7; i++) begin
      acc(1'b1, i[6:0], 8'h00, 1'b0, 8'h00);
      acc(1'b0, i[6:0], 8'h00, 1'b0, 8'h00);
    end
    acc(1'b1, 7'h08, 8'h5A, 1'b1, 8'h00);
    acc(1'b0, 7'h08, 8'h00, 1'b1, 8'h00);
    @(posedge i_clock);
    adc_powered <= 1'b0;
    // Coefficient 0 over bytes 8..10, then the last byte of the page
    acc(1'b1, 7'h08, 8'h12, 1'b0, 8'h00);
    acc(1'b1, 7'h09, 8'h34, 1'b0, 8'h00);
    acc(1'b1, 7'h0A, 8'h56, 1'b0, 8'h00);
    acc(1'b1, 7'h7F, 8'hA5, 1'b0, 8'h00);
    acc(1'b0, 7'h7F, 8'h00, 1'b0, 8'hA5);
    acc(1'b0, 7'h08, 8'h00, 1'b0, 8'h12);
    filt(9'd0, 24'h123456);
    // First bytes of the second page form coefficient 30
    page(8'h09);
    acc(1'b1, 7'h08, 8'hC3, 1'b0, 8'h00);
    acc(1'b1, 7'h09, 8'h0F, 1'b0, 8'h00);
    acc(1'b1, 7'h0A, 8'h1E, 1'b0, 8'h00);
    filt(9'd30, 24'hC30F1E);
    page(8'h08);
    acc(1'b1, 7'h01, 8'h04, 1'b0, 8'h00);
    acc(1'b0, 7'h01, 8'h00, 1'b0, 8'h04);
    check({23'h0, adapt_en}, 24'h1, "adapt on");
    @(posedge i_clock);
    adc_powered <= 1'b1;
    // Filter owns A, host reaches B
    acc(1'b0, 7'h08, 8'h00, 1'b1, 8'h00);
    page(8'h1A);
    acc(1'b1, 7'h08, 8'h65, 1'b0, 8'h00);
    acc(1'b1, 7'h09, 8'h43, 1'b0, 8'h00);
    acc(1'b1, 7'h0A, 8'h21, 1'b0, 8'h00);
    page(8'h08);
    acc(1'b1, 7'h01, 8'h05, 1'b0, 8'h00);
    acc(1'b0, 7'h01, 8'h00, 1'b0, 8'h05);
    check({23'h0, active_b}, 24'h0, "no early swap");
    filt(9'd0, 24'h123456);
    frame();
    acc(1'b0, 7'h01, 8'h00, 1'b0, 8'h06);
    check({23'h0, active_b}, 24'h1, "flag after swap");
    filt(9'd0, 24'h654321);
    acc(1'b0, 7'h08, 8'h00, 1'b0, 8'h12);
    page(8'h1A);
    acc(1'b0, 7'h08, 8'h00, 1'b1, 8'h00);
    // A plain enable write asks for no exchange
    page(8'h08);
    acc(1'b1, 7'h01, 8'h04, 1'b0, 8'h00);
    frame();
    acc(1'b0, 7'h01, 8'h00, 1'b0, 8'h06);
    check({23'h0, active_b}, 24'h1, "flag kept");
    // Leaving adaptive mode points the filter back at A and relocks
    acc(1'b1, 7'h01, 8'h00, 1'b0, 8'h00);
    acc(1'b0, 7'h01, 8'h00, 1'b0, 8'h00);
    check({23'h0, active_b}, 24'h0, "flag cleared");
    filt(9'd0, 24'h123456);
    acc(1'b0, 7'h08, 8'h00, 1'b1, 8'h00);
    summarize();
  end
endmodule : adc_adaptive_coef_pingpong_tb
